// >>> verilog/debug_port_ctrl_link_regs.sv
// Purpose: control/status, link control and identity registers of a debug port
// Assumes: link request fields stable around the rising link clock edge
// Notes: link inputs reach clk through two flops; edges found on clk
//
// Contract
// RQ1: serial wire: error flag read-only, cleared by abort error-clear bit, resets zero.
// RQ2: compare flag sets on compare mismatch or verify match; resets zero.
// RQ3: jtag: compare flag write-one-clear; abort error-clear also clears it.
// RQ4: serial wire: compare flag read-only, cleared by abort compare-clear bit.
// RQ5: mode field bits 3:2: normal, pushed-verify, pushed-compare, reserved.
// RQ6: pushed modes turn an access-port write into read plus compare.
// RQ7: minimal configuration: debugger writes only zero to mode and count fields.
// RQ8: with detection enabled, overrun sets the overrun flag; resets zero.
// RQ9: jtag: overrun flag write-one-clear; abort error-clear also clears it.
// RQ10: serial wire: overrun flag read-only, cleared by abort overrun-clear bit.
// RQ11: bit 0 enables overrun detection; resets zero.
// RQ12: control/status decoded at offset 0x4, bank 0x0.
// RQ13: jtag: link control register reserved, reads zero.
// RQ14: turnaround field bits 9:8 selects one to four data periods.
// RQ15: turnaround field resets to one period on power-up and line reset.
// RQ16: without variable turnaround, nonzero turnaround write is a protocol error.
// RQ17: link control decoded at offset 0x4, bank 0x1.
// RQ18: identity bits 31:28 hold the configured instance number.
// RQ19: identity bits 3:0 give protocol version; bits 27:4 read zero.
// RQ20: link protocol identity read-only at offset 0x4, bank 0x3.
// RQ21: port identity read-only 32 bits, bank select ignored.
// RQ22: port identity at offset 0x0, bit 0 reads one.
// RQ23: a set event in the clearing cycle keeps the flag set.
`timescale 1ns/1ps

module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // sync_two_flop

module debug_port_ctrl_link_regs
  import debug_port_pkg::*;
#(
  parameter bit SERIAL_WIRE_VARIANT = 1'b1,
  parameter bit VARIABLE_TURNAROUND = 1'b1,
  parameter logic [3:0] TARGET_INSTANCE = 4'h0,
  parameter logic [3:0] PROTOCOL_VERSION = 4'h1,
  // arbitrary neutral identity value
  parameter logic [31:0] PORT_IDENTITY_VALUE = 32'h1000_0001
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire link_req_s link_in,
  output logic link_ack,
  output logic [31:0] link_rdata,
  input wire logic [3:0] bank_select,
  input wire logic line_reset,
  input wire logic ap_error,
  input wire logic overrun_event,
  input wire logic ap_txn_valid,
  input wire ap_txn_s ap_txn,
  output logic ap_issue_valid,
  output ap_txn_s ap_issue,
  input wire logic ap_rdata_valid,
  input wire logic [31:0] ap_rdata,
  output logic [1:0] turnaround_period,
  output logic protocol_error
);

  // ****************************************************************
  // link input crossing and edge detection
  // ****************************************************************
  localparam int LINK_W = $bits(link_req_s) + 1;
  logic [LINK_W-1:0] link_sync;
  logic link_clk_s;
  logic link_clk_d_r;
  link_req_s req_s;
  logic take;

  sync_two_flop #(.WIDTH(LINK_W)) u_link_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({link_clk, link_in}),
    .q(link_sync)
  );

  assign link_clk_s = link_sync[LINK_W-1];
  assign req_s = link_sync[LINK_W-2:0];

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      link_clk_d_r <= 1'b0;
    else
      link_clk_d_r <= link_clk_s;
  end

  // request sampled at the rising link clock edge seen on clk
  assign take = link_clk_s && !link_clk_d_r && req_s.req;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic sel_port_id;
  logic sel_cs;
  logic sel_lc;
  logic sel_lpi;
  logic wr_cs;
  logic wr_lc;
  logic wr_abort;

  always_comb
  begin
    sel_port_id = 1'b0;
    sel_cs = 1'b0;
    sel_lc = 1'b0;
    sel_lpi = 1'b0;
    if (req_s.addr == OFS_PORT_IDENTITY)
      sel_port_id = 1'b1; // [RQ21] [RQ22]
    else if (req_s.addr == OFS_BANKED && bank_select == BANK_CONTROL_STATUS)
      sel_cs = 1'b1; // [RQ12]
    else if (req_s.addr == OFS_BANKED && bank_select == BANK_LINK_CONTROL)
      sel_lc = 1'b1; // [RQ17]
    else if (req_s.addr == OFS_BANKED && bank_select == BANK_LINK_PROTOCOL_IDENTITY)
      sel_lpi = 1'b1; // [RQ20]
  end

  // a write at the identity offset lands in the abort register
  assign wr_abort = take && req_s.write && sel_port_id;
  assign wr_cs = take && req_s.write && sel_cs;
  assign wr_lc = take && req_s.write && sel_lc;

  // ****************************************************************
  // sticky flag clear terms
  // ****************************************************************
  logic clr_err;
  logic clr_cmp;
  logic clr_orun;
  logic cmp_event;

  always_comb
  begin
    if (SERIAL_WIRE_VARIANT)
    begin
      // control/status writes never touch the flags here
      clr_err = wr_abort && req_s.wdata[ABORT_ERR_CLR_BIT]; // [RQ1]
      clr_cmp = wr_abort && req_s.wdata[ABORT_CMP_CLR_BIT]; // [RQ4]
      clr_orun = wr_abort && req_s.wdata[ABORT_ORUN_CLR_BIT]; // [RQ10]
    end
    else
    begin
      clr_err = (wr_abort && req_s.wdata[ABORT_ERR_CLR_BIT])
        || (wr_cs && req_s.wdata[CS_ERR_BIT]);
      clr_cmp = (wr_abort && req_s.wdata[ABORT_ERR_CLR_BIT])
        || (wr_cs && req_s.wdata[CS_CMP_BIT]); // [RQ3]
      clr_orun = (wr_abort && req_s.wdata[ABORT_ERR_CLR_BIT])
        || (wr_cs && req_s.wdata[CS_ORUN_BIT]); // [RQ9]
    end
  end

  // ****************************************************************
  // control/status register
  // ****************************************************************
  logic sticky_error_flag_r;
  logic sticky_compare_flag_r;
  logic sticky_overrun_flag_r;
  logic [1:0] transfer_mode_select_r;
  logic overrun_detect_enable_r;

  // set beats clear in every flag below
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      sticky_error_flag_r <= 1'b0; // [RQ1]
    else if (ap_error)
      sticky_error_flag_r <= 1'b1; // [RQ23]
    else if (clr_err)
      sticky_error_flag_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      sticky_compare_flag_r <= 1'b0;
    else if (cmp_event)
      sticky_compare_flag_r <= 1'b1; // [RQ2] [RQ23]
    else if (clr_cmp)
      sticky_compare_flag_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      sticky_overrun_flag_r <= 1'b0;
    else if (overrun_event && overrun_detect_enable_r)
      sticky_overrun_flag_r <= 1'b1; // [RQ8] [RQ23]
    else if (clr_orun)
      sticky_overrun_flag_r <= 1'b0;
  end

  // minimal-configuration software keeps these at zero; stored as written
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      transfer_mode_select_r <= MODE_RESET;
      overrun_detect_enable_r <= 1'b0; // [RQ11]
    end
    else if (wr_cs)
    begin
      transfer_mode_select_r <= req_s.wdata[CS_MODE_HI:CS_MODE_LO]; // [RQ5] [RQ7]
      overrun_detect_enable_r <= req_s.wdata[CS_ORUN_EN_BIT]; // [RQ11]
    end
  end

  // ****************************************************************
  // link control register
  // ****************************************************************
  logic [1:0] turn_r;
  logic proto_err_r;
  logic [1:0] turn_wr;

  assign turn_wr = req_s.wdata[LC_TURN_HI:LC_TURN_LO];

  always_ff @(posedge clk)
  begin
    if (!reset_n || line_reset)
      turn_r <= TURN_RESET; // [RQ15]
    else if (wr_lc && SERIAL_WIRE_VARIANT && VARIABLE_TURNAROUND)
      turn_r <= turn_wr; // [RQ14]
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      proto_err_r <= 1'b0;
    else
      proto_err_r <= wr_lc && SERIAL_WIRE_VARIANT && !VARIABLE_TURNAROUND
        && (turn_wr != TURN_RESET); // [RQ16]
  end

  assign turnaround_period = turn_r;
  assign protocol_error = proto_err_r;

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [31:0] rd_word;
  logic [31:0] link_rdata_r;
  logic link_ack_r;

  always_comb
  begin
    rd_word = WORD_ZERO;
    if (sel_port_id)
    begin
      rd_word = PORT_IDENTITY_VALUE; // [RQ21]
      rd_word[PID_ONE_BIT] = 1'b1; // [RQ22]
    end
    else if (sel_cs)
    begin
      rd_word[CS_ERR_BIT] = sticky_error_flag_r;
      rd_word[CS_CMP_BIT] = sticky_compare_flag_r;
      rd_word[CS_MODE_HI:CS_MODE_LO] = transfer_mode_select_r;
      rd_word[CS_ORUN_BIT] = sticky_overrun_flag_r;
      rd_word[CS_ORUN_EN_BIT] = overrun_detect_enable_r;
    end
    else if (sel_lc)
    begin
      if (SERIAL_WIRE_VARIANT)
        rd_word[LC_TURN_HI:LC_TURN_LO] = turn_r;
      else
        rd_word = WORD_ZERO; // [RQ13]
    end
    else if (sel_lpi)
    begin
      rd_word[LPI_INST_HI:LPI_INST_LO] = TARGET_INSTANCE; // [RQ18]
      rd_word[LPI_VER_HI:LPI_VER_LO] = PROTOCOL_VERSION; // [RQ19]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      link_rdata_r <= WORD_ZERO;
      link_ack_r <= 1'b0;
    end
    else
    begin
      link_ack_r <= take;
      if (take && !req_s.write)
        link_rdata_r <= rd_word;
    end
  end

  assign link_ack = link_ack_r;
  assign link_rdata = link_rdata_r;

  // ****************************************************************
  // access-port pass-through and pushed operations
  // ****************************************************************
  push_state_e state_r;
  logic [31:0] push_data_r;
  logic push_verify_r;
  logic issue_valid_r;
  ap_txn_s issue_r;
  logic pushed;
  logic words_match;

  assign pushed = (transfer_mode_select_r == MODE_PUSHED_VERIFY)
    || (transfer_mode_select_r == MODE_PUSHED_COMPARE);
  assign words_match = (ap_rdata == push_data_r);
  // reserved mode behaves as normal pass-through
  assign cmp_event = (state_r == st_read_wait) && ap_rdata_valid
    && (push_verify_r ? words_match : !words_match); // [RQ2]

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_r <= st_idle;
      push_data_r <= WORD_ZERO;
      push_verify_r <= 1'b0;
      issue_valid_r <= 1'b0;
      issue_r <= '0;
    end
    else
    begin
      issue_valid_r <= 1'b0;
      case (state_r)
        st_idle:
        begin
          if (ap_txn_valid && ap_txn.write && pushed)
          begin
            // write becomes a read; the data is kept for the compare
            issue_valid_r <= 1'b1; // [RQ6]
            issue_r.write <= 1'b0;
            issue_r.data <= WORD_ZERO;
            push_data_r <= ap_txn.data;
            push_verify_r <= (transfer_mode_select_r == MODE_PUSHED_VERIFY);
            state_r <= st_read_wait;
          end
          else if (ap_txn_valid)
          begin
            issue_valid_r <= 1'b1;
            issue_r <= ap_txn;
          end
        end
        st_read_wait:
        begin
          // new transactions during the wait are dropped
          if (ap_rdata_valid)
            state_r <= st_idle; // [RQ6]
        end
        default:
          state_r <= st_idle;
      endcase
    end
  end

  assign ap_issue_valid = issue_valid_r;
  assign ap_issue = issue_r;

endmodule // debug_port_ctrl_link_regs

// >>> verilog/debug_port_pkg.sv
// Purpose: shared constants and types for the debug port register bank
// Assumes: link word accesses, 4-bit port offsets with low two bits zero
// Notes: abort bit positions and identity values are local choices
package debug_port_pkg;

  // ****************************************************************
  // port offsets and bank select values
  // ****************************************************************
  localparam logic [3:0] OFS_PORT_IDENTITY = 4'h0;
  localparam logic [3:0] OFS_BANKED = 4'h4;
  localparam logic [3:0] BANK_CONTROL_STATUS = 4'h0;
  localparam logic [3:0] BANK_LINK_CONTROL = 4'h1;
  localparam logic [3:0] BANK_LINK_PROTOCOL_IDENTITY = 4'h3;

  // ****************************************************************
  // control/status field positions
  // ****************************************************************
  localparam int CS_ERR_BIT = 5;
  localparam int CS_CMP_BIT = 4;
  localparam int CS_MODE_HI = 3;
  localparam int CS_MODE_LO = 2;
  localparam int CS_ORUN_BIT = 1;
  localparam int CS_ORUN_EN_BIT = 0;

  // transfer mode encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PUSHED_VERIFY = 2'h1;
  localparam logic [1:0] MODE_PUSHED_COMPARE = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // ****************************************************************
  // link control, identity and abort fields
  // ****************************************************************
  localparam int LC_TURN_HI = 9;
  localparam int LC_TURN_LO = 8;
  localparam logic [1:0] TURN_RESET = 2'h0;
  localparam int LPI_INST_HI = 31;
  localparam int LPI_INST_LO = 28;
  localparam int LPI_VER_HI = 3;
  localparam int LPI_VER_LO = 0;
  localparam int PID_ONE_BIT = 0;
  localparam int ABORT_ERR_CLR_BIT = 2;
  localparam int ABORT_CMP_CLR_BIT = 1;
  localparam int ABORT_ORUN_CLR_BIT = 4;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic req;
    logic write;
    logic [3:0] addr;
    logic [31:0] wdata;
  } link_req_s;

  typedef struct packed {
    logic write;
    logic [31:0] data;
  } ap_txn_s;

  typedef enum logic [0:0] {st_idle, st_read_wait} push_state_e;

endpackage

// >>> testbench/debug_port_ctrl_link_regs_properties.sv
// Purpose: port-level checks for the debug port register bank
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module debug_port_ctrl_link_regs_checker
  import debug_port_pkg::*;
#(
  parameter bit VARIABLE_TURNAROUND = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire link_req_s link_in,
  input wire logic link_ack,
  input wire logic [31:0] link_rdata,
  input wire logic line_reset,
  input wire logic ap_txn_valid,
  input wire ap_txn_s ap_txn,
  input wire logic ap_issue_valid,
  input wire ap_txn_s ap_issue,
  input wire logic [1:0] turnaround_period,
  input wire logic protocol_error
);
  // ********
  // link, turnaround and access port timing
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_link_take;
    $rose(link_clk) && link_in.req;
  endsequence
  sequence s_ack_once;
    link_ack ##1 !link_ack;
  endsequence
  property p_link_answer;
    s_link_take |-> ##[2:6] s_ack_once;
  endproperty
  property p_ack_cause;
    link_ack |-> link_in.req && link_clk;
  endproperty
  property p_rdata_hold;
    $changed(link_rdata) |-> link_ack;
  endproperty
  property p_turn_line_reset;
    line_reset |=> turnaround_period == 2'h0;
  endproperty
  // sync flops may still be draining, so only the register outputs are checked
  property p_turn_por;
    $rose(reset_n) |-> turnaround_period == 2'h0 && !link_ack && !ap_issue_valid;
  endproperty
  property p_turn_change;
    $changed(turnaround_period) && !$past(line_reset) |-> ##[0:1] link_ack;
  endproperty
  property p_perr;
    VARIABLE_TURNAROUND ? !protocol_error : turnaround_period == 2'h0;
  endproperty
  property p_issue_cause;
    ap_issue_valid |-> $past(ap_txn_valid);
  endproperty
  property p_issue_write;
    ap_issue_valid && ap_issue.write |-> $past(ap_txn.write) && ap_issue.data == $past(ap_txn.data);
  endproperty
  a_link_answer: assert property (p_link_answer)
    else $error("link edge not answered once");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without ack");
  a_turn_line_reset: assert property (p_turn_line_reset)
    else $error("line reset left turnaround set");
  a_turn_por: assert property (p_turn_por)
    else $error("outputs not clear after reset");
  a_turn_change: assert property (p_turn_change)
    else $error("turnaround moved without write");
  a_perr: assert property (p_perr)
    else $error("turnaround error handling wrong");
  a_issue_cause: assert property (p_issue_cause)
    else $error("issue without transaction");
  a_issue_write: assert property (p_issue_write)
    else $error("issued write differs");
endmodule // debug_port_ctrl_link_regs_checker

bind debug_port_ctrl_link_regs debug_port_ctrl_link_regs_checker #(
  .VARIABLE_TURNAROUND(VARIABLE_TURNAROUND)
) chk_inst (
  .clk(clk),
  .reset_n(reset_n),
  .link_clk(link_clk),
  .link_in(link_in),
  .link_ack(link_ack),
  .link_rdata(link_rdata),
  .line_reset(line_reset),
  .ap_txn_valid(ap_txn_valid),
  .ap_txn(ap_txn),
  .ap_issue_valid(ap_issue_valid),
  .ap_issue(ap_issue),
  .turnaround_period(turnaround_period),
  .protocol_error(protocol_error)
);

// >>> testbench/link_debugger.sv
// Purpose: external debugger model on the link side
// Assumes: request held until ack is sampled on clk
// Notes: link clock idles low between frames
`timescale 1ns/1ps
module link_debugger
  import debug_port_pkg::*;
(
  input wire logic clk,
  input wire logic link_ack,
  output logic link_clk,
  output link_req_s link_in
);
  initial
  begin
    link_clk = 1'b0;
    link_in = '0;
  end
  // ********
  // one word per frame
  // ********
  // odd delay keeps the request and the rising link edge off the clk edge; the release lands on a clk edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    #163 link_in = '{1'b1, w, a, d};
    #163 link_clk = 1'b1;
    do
      @(posedge clk);
    while (link_ack !== 1'b1);
    link_clk <= 1'b0;
    // released lines show the inverse, not stale data
    link_in <= '{1'b0, !w, ~a, ~d};
  endtask
endmodule // link_debugger

// >>> testbench/tb_debug_port_ctrl_link_regs.sv
// Purpose: self-checking bench for the debug port register bank
// Assumes: serial wire variant with variable turnaround
// Notes: link words go through the debugger model
`timescale 1ns/1ps
module tb_debug_port_ctrl_link_regs
  import debug_port_pkg::*;
;
  // arbitrary identity value; bit 0 left clear so the forced one is visible
  localparam logic [31:0] PID = 32'h1000_0010;
  localparam logic [31:0] LPI = 32'h5000_0001;
  logic clk, reset_n, link_clk, link_ack, line_reset, ap_error, overrun_event;
  logic ap_txn_valid, ap_issue_valid, ap_rdata_valid, protocol_error, pu, fl;
  logic [3:0] bank_select;
  logic [2:0] ev;
  logic [1:0] turnaround_period;
  logic [31:0] link_rdata, ap_rdata, seed_r, d;
  link_req_s link_in;
  ap_txn_s ap_txn, ap_issue;
  int failures, total_checks, mo;
  int cycles = 0;
  logic [32:0] rdq[$];
  ap_txn_s isq[$];
  assign {overrun_event, ap_error, line_reset} = ev;
  debug_port_ctrl_link_regs #(.TARGET_INSTANCE(4'h5), .PORT_IDENTITY_VALUE(PID))
    debug_port_ctrl_link_regs_inst (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
    .link_in(link_in), .link_ack(link_ack), .link_rdata(link_rdata),
    .bank_select(bank_select), .line_reset(line_reset), .ap_error(ap_error),
    .overrun_event(overrun_event), .ap_txn_valid(ap_txn_valid), .ap_txn(ap_txn),
    .ap_issue_valid(ap_issue_valid), .ap_issue(ap_issue), .ap_rdata_valid(ap_rdata_valid),
    .ap_rdata(ap_rdata), .turnaround_period(turnaround_period),
    .protocol_error(protocol_error));
  link_debugger dbg_inst (.clk(clk), .link_ack(link_ack), .link_clk(link_clk),
    .link_in(link_in));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ********
  // helpers
  // ********
  function automatic logic [31:0] rnd();
    seed_r ^= seed_r << 13;
    seed_r ^= seed_r >> 17;
    seed_r ^= seed_r << 5;
    return seed_r;
  endfunction
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_issue(input ap_txn_s got);
    ap_txn_s e;
    if (isq.size() > 0)
      e = isq.pop_front();
    else
      e = '{1'bx, 32'h0000_0000};
    cmp_word({31'h0, got.write}, {31'h0, e.write});
    if (e.write)
      cmp_word(got.data, e.data);
  endtask
  task automatic lk(input logic w, input logic [3:0] a, b, input logic [31:0] v);
    @(posedge clk);
    bank_select <= b;
    rdq.push_back({!w, v});
    dbg_inst.xfer(w, a, w ? v : rnd());
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 3'(1 << i);
    @(posedge clk);
    ev <= 3'h0;
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ********
  // result watcher and hang guard
  // ********
  always @(posedge clk)
  begin
    cycles++;
    if (link_ack === 1'b1 && rdq.size() > 0)
    begin
      if (rdq[0][32])
        cmp_word(link_rdata, rdq[0][31:0]);
      void'(rdq.pop_front());
    end
    else if (link_ack === 1'b1)
      cmp_word(32'h0000_0001, 32'h0000_0000);
    if (ap_issue_valid === 1'b1)
      cmp_issue(ap_issue);
    if (cycles == 6000)
    begin
      failures++;
      give_verdict();
    end
  end
  initial
  begin
    seed_r = 32'h0000_2505;
    reset_n = 1'b0;
    ev = 3'h0;
    bank_select = 4'h0;
    ap_txn_valid = 1'b0;
    ap_txn = '0;
    ap_rdata_valid = 1'b0;
    ap_rdata = 32'h0000_0000;
    failures = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    lk(0, 4'h0, 4'h7, PID | 32'h0000_0001);
    lk(0, 4'h4, 4'h0, 32'h0000_0000);
    lk(0, 4'h4, 4'h1, 32'h0000_0000);
    lk(0, 4'h4, 4'h3, LPI);
    lk(1, 4'h4, 4'h3, rnd());
    lk(0, 4'h4, 4'h3, LPI);
    lk(0, 4'h8, 4'h0, 32'h0000_0000);
    $display("test identity done");
    for (int t = 0; t < 4; t++)
    begin
      lk(1, 4'h4, 4'h1, (rnd() & 32'hFFFF_FCFF) | 32'(t << 8));
      @(posedge clk);
      cmp_word({30'h0, turnaround_period}, 32'(t));
      lk(0, 4'h4, 4'h1, 32'(t << 8));
    end
    pulse(0);
    @(posedge clk);
    cmp_word({30'h0, turnaround_period}, 32'h0000_0000);
    $display("test turnaround done");
    lk(1, 4'h4, 4'h0, 32'h0000_0001);
    pulse(2);
    pulse(1);
    lk(0, 4'h4, 4'h0, 32'h0000_0023);
    lk(1, 4'h4, 4'h0, 32'h0000_0033);
    lk(0, 4'h4, 4'h0, 32'h0000_0023);
    lk(1, 4'h0, 4'h0, 32'h0000_0010);
    lk(0, 4'h4, 4'h0, 32'h0000_0021);
    lk(1, 4'h0, 4'h0, 32'h0000_0004);
    lk(0, 4'h4, 4'h0, 32'h0000_0001);
    lk(1, 4'h4, 4'h0, 32'h0000_0000);
    pulse(2);
    lk(0, 4'h4, 4'h0, 32'h0000_0000);
    // error event sampled on the take edge of its own clear, eleven edges in
    fork
      lk(1, 4'h0, 4'h0, 32'h0000_0004);
      begin
        repeat (11) @(posedge clk);
        ev <= 3'h2;
        @(posedge clk);
        ev <= 3'h0;
      end
    join
    lk(0, 4'h4, 4'h0, 32'h0000_0020);
    lk(1, 4'h0, 4'h0, 32'h0000_0004);
    $display("test flags done");
    // mode in m[2:1], read-back match in m[0]
    for (int m = 0; m < 8; m++)
    begin
      mo = m >> 1;
      pu = (mo == 1) || (mo == 2);
      fl = (mo == 1 && m[0]) || (mo == 2 && !m[0]);
      lk(1, 4'h4, 4'h0, 32'(mo << 2));
      d = rnd();
      @(posedge clk);
      ap_txn_valid <= 1'b1;
      ap_txn <= '{1'b1, d};
      isq.push_back('{!pu, d});
      if (!pu)
        isq.push_back('{1'b1, ~d});
      @(posedge clk);
      ap_txn <= '{1'b1, ~d};
      @(posedge clk);
      ap_txn_valid <= 1'b0;
      repeat (3) @(posedge clk);
      ap_rdata_valid <= pu;
      ap_rdata <= m[0] ? d : ~d;
      @(posedge clk);
      ap_rdata_valid <= 1'b0;
      lk(0, 4'h4, 4'h0, 32'({fl, 4'h0} | (mo << 2)));
      lk(1, 4'h0, 4'h0, 32'h0000_0002);
    end
    $display("test pushed done");
    repeat (4) @(posedge clk);
    cmp_word(32'(rdq.size() + isq.size()), 32'h0000_0000);
    give_verdict();
  end
endmodule // tb_debug_port_ctrl_link_regs
